// [core/flpw_lock.sv]
`timescale 1ns/1ns
// Function
// - Set-freeze sets freeze bit seven
// - Set-freeze needs write enable latch set
// - Set-freeze runs only if select rises after eight
// - Busy during freeze; then busy, latch cleared
// - Secret readable only programmed, password mode off
// - Secret out falling edges, low byte first
// - Secret read only in single-line mode
// - Program secret needs latch, refused in password mode
// - Program secret needs exactly 64 data bits
// - Busy during program; then busy, latch cleared
// - Unlock needs exactly 64 bits; busy meanwhile
// - Unlock mismatch ignored; match sets lock flag
// - Gang-lock with latch clears all dynamic bits
// - Gang-lock both modes, byte boundary, busy meanwhile
// - Gang-unlock with latch sets all dynamic bits
// - Gang-unlock both modes, byte boundary, busy meanwhile
// - Instruction bits sampled on rising clock
// - Clear-lock with latch clears lock flag
// - Protection register 16 bits, low byte first
module flpw_lock #(
    parameter int NUM_DYN = 16,                    // Dynamic protection bits
    parameter int OP_CYCLES = flpw_pkg::OP_CYC     // Internal operation length
) (
    input  wire logic               CLK_SYS,
    input  wire logic               RSTN,
    input  wire logic               SCK,           // Serial clock pin
    input  wire logic               CS_N,          // Chip select pin
    input  wire logic [3:0]         IO_IN,         // Data pins, bit 0 is serial in
    input  wire logic               QUAD_COMMAND_MODE,
    input  wire logic [15:0]        ADVANCED_PROTECTION_REG,
    output logic                    SO_OUT,        // Serial out (IO1)
    output logic                    SO_OE,
    output logic                    BUSY_FLAG,
    output logic                    WRITE_ENABLE_LATCH,
    output logic [7:0]              LOCK_REG,      // Freeze bit and lock flag
    output logic                    SECRET_SET,    // Secret has been programmed
    output logic [NUM_DYN-1:0]      DYNAMIC_PROTECT_BIT
);
    localparam logic [15:0] OPC_W = 16'(OP_CYCLES);

    flpw_pkg::flpw_pin_t pin_raw;       // Raw pins
    flpw_pkg::flpw_pin_t pin_s;         // Synchronised pins
    logic                sck_q_ff;      // Previous clock level
    logic                csn_q_ff;      // Previous select level
    logic                sck_rise;      // Rising link clock
    logic                sck_fall;      // Falling link clock
    logic                cs_rise;       // End of frame
    logic [71:0]         sh_ff;         // Frame shift register
    logic [71:0]         nxt_sh;
    logic [6:0]          cnt_ff;        // Bits received this frame
    logic [6:0]          nxt_cnt;
    logic [7:0]          cmd_ff;        // Latched opcode
    flpw_pkg::flpw_rd_t  rd_ff;         // Read stream kind
    flpw_pkg::flpw_rd_t  nxt_rd;
    logic [5:0]          idx_ff;        // Output bit index
    flpw_pkg::flpw_op_t  op_ff;         // Running operation
    flpw_pkg::flpw_op_t  nxt_op;        // Operation to start
    logic [15:0]         opc_ff;        // Operation countdown
    logic                op_done;       // Last cycle of operation
    logic [63:0]         new_secret_ff; // Data captured for program or unlock
    logic [63:0]         rx_secret;     // Received data, byte order fixed
    logic [63:0]         secret_ff;     // Stored secret
    logic                pw_mode_off;   // Password mode not selected
    logic                out_bit;       // Bit for next falling edge
    logic [7:0]          status_byte;

    // Byte swap: first received byte is byte 0
    function automatic logic [63:0] swap_bytes(input logic [63:0] v);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
            r[i*8 +: 8] = v[(7-i)*8 +: 8];
        return r;
    endfunction : swap_bytes

    // Pins into system clock
    assign pin_raw.sck = SCK;
    assign pin_raw.csn = CS_N;
    assign pin_raw.io  = IO_IN;

    flpw_sync #(
        .W   (6),
        .RST (6'h10)
    ) u_sync (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .din   (pin_raw),
        .dout  (pin_s)
    );

    // Edge history of synchronised pins
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sck_q_ff <= 1'b0;
            csn_q_ff <= 1'b1;
        end
        else
        begin
            sck_q_ff <= pin_s.sck;
            csn_q_ff <= pin_s.csn;
        end
    end

    assign sck_rise    = pin_s.sck & ~sck_q_ff & ~pin_s.csn;
    assign sck_fall    = ~pin_s.sck & sck_q_ff & ~pin_s.csn;
    assign cs_rise     = pin_s.csn & ~csn_q_ff;
    assign pw_mode_off = ADVANCED_PROTECTION_REG[flpw_pkg::PWMODE_POS];
    assign rx_secret   = swap_bytes(sh_ff[63:0]);

    // Next shift value and count on a rising link clock
    always_comb
    begin
        if (QUAD_COMMAND_MODE)
        begin
            nxt_sh  = {sh_ff[67:0], pin_s.io};
            nxt_cnt = (cnt_ff > flpw_pkg::CNT_MAX - 7'h04) ? flpw_pkg::CNT_MAX
                                                           : cnt_ff + 7'h04;
        end
        else
        begin
            nxt_sh  = {sh_ff[70:0], pin_s.io[0]};
            nxt_cnt = (cnt_ff == flpw_pkg::CNT_MAX) ? cnt_ff : cnt_ff + 7'h01;
        end
    end

    // Frame capture, opcode latched at the eighth bit
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sh_ff  <= '0;
            cnt_ff <= '0;
            cmd_ff <= '0;
        end
        else if (pin_s.csn)
            cnt_ff <= '0;                          // Idle between frames
        else if (sck_rise)
        begin
            sh_ff  <= nxt_sh;
            cnt_ff <= nxt_cnt;
            if (nxt_cnt == flpw_pkg::INSTR_BITS)
                cmd_ff <= nxt_sh[7:0];
        end
    end

    // Read stream chosen once the opcode is in
    always_comb
    begin
        nxt_rd = flpw_pkg::RD_NONE;
        if (nxt_sh[7:0] == flpw_pkg::OPC_READ_STATUS)
            nxt_rd = flpw_pkg::RD_STATUS;
        else if (op_ff == flpw_pkg::OP_NONE)
        begin
            if (nxt_sh[7:0] == flpw_pkg::OPC_READ_SECRET && !QUAD_COMMAND_MODE
                && SECRET_SET && pw_mode_off)
                nxt_rd = flpw_pkg::RD_SECRET;
            else if (nxt_sh[7:0] == flpw_pkg::OPC_READ_PROTECT && !QUAD_COMMAND_MODE)
                nxt_rd = flpw_pkg::RD_PROTECT;
        end
    end

    assign status_byte = {6'h00, WRITE_ENABLE_LATCH, BUSY_FLAG};

    // Bit to drive: low byte first, top bit of byte first
    always_comb
    begin
        unique case (rd_ff)
            flpw_pkg::RD_STATUS:  out_bit = status_byte[~idx_ff[2:0]];
            flpw_pkg::RD_SECRET:  out_bit = secret_ff[{idx_ff[5:3], ~idx_ff[2:0]}];
            flpw_pkg::RD_PROTECT: out_bit =
                ADVANCED_PROTECTION_REG[{idx_ff[3], ~idx_ff[2:0]}];
            flpw_pkg::RD_NONE:    out_bit = 1'b0;
        endcase
    end

    // Serial output on falling link clock, wraps every 64/16/8 bits
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rd_ff  <= flpw_pkg::RD_NONE;
            idx_ff <= '0;
            SO_OUT <= 1'b0;
            SO_OE  <= 1'b0;
        end
        else if (pin_s.csn)
        begin
            rd_ff  <= flpw_pkg::RD_NONE;
            idx_ff <= '0;
            SO_OE  <= 1'b0;
        end
        else if (sck_rise && nxt_cnt == flpw_pkg::INSTR_BITS && cnt_ff < nxt_cnt)
            rd_ff <= nxt_rd;
        else if (sck_fall && rd_ff != flpw_pkg::RD_NONE)
        begin
            SO_OUT <= out_bit;
            SO_OE  <= 1'b1;
            idx_ff <= idx_ff + 6'h01;
        end
    end

    // Decide at select rise which operation starts
    always_comb
    begin
        nxt_op = flpw_pkg::OP_NONE;
        if (cs_rise && op_ff == flpw_pkg::OP_NONE && WRITE_ENABLE_LATCH)
        begin
            unique case (cmd_ff)
                flpw_pkg::OPC_SET_FREEZE:
                    if (cnt_ff == flpw_pkg::INSTR_BITS)
                        nxt_op = flpw_pkg::OP_FREEZE;
                flpw_pkg::OPC_CLEAR_LOCK:
                    if (cnt_ff == flpw_pkg::INSTR_BITS)
                        nxt_op = flpw_pkg::OP_CLRLOCK;
                flpw_pkg::OPC_PROGRAM_SECRET:
                    if (cnt_ff == flpw_pkg::SECRET_BITS && pw_mode_off)
                        nxt_op = flpw_pkg::OP_PROGRAM;
                flpw_pkg::OPC_GANG_LOCK:
                    if (cnt_ff != 7'h00 && cnt_ff[2:0] == 3'h0)
                        nxt_op = flpw_pkg::OP_GLOCK;
                flpw_pkg::OPC_GANG_UNLOCK:
                    if (cnt_ff != 7'h00 && cnt_ff[2:0] == 3'h0)
                        nxt_op = flpw_pkg::OP_GUNLOCK;
                default:
                    nxt_op = flpw_pkg::OP_NONE;
            endcase
        end
        // Unlock does not need the latch
        if (cs_rise && op_ff == flpw_pkg::OP_NONE
            && cmd_ff == flpw_pkg::OPC_UNLOCK_SECRET && cnt_ff == flpw_pkg::SECRET_BITS)
            nxt_op = flpw_pkg::OP_UNLOCK;
    end

    assign op_done = (op_ff != flpw_pkg::OP_NONE) && (opc_ff == 16'h0001);

    // Operation timer and busy flag
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            op_ff     <= flpw_pkg::OP_NONE;
            opc_ff    <= '0;
            BUSY_FLAG <= 1'b0;
        end
        else if (nxt_op != flpw_pkg::OP_NONE)
        begin
            op_ff     <= nxt_op;
            opc_ff    <= OPC_W;
            BUSY_FLAG <= 1'b1;
        end
        else if (op_done)
        begin
            op_ff     <= flpw_pkg::OP_NONE;
            BUSY_FLAG <= 1'b0;
        end
        else if (op_ff != flpw_pkg::OP_NONE)
            opc_ff <= opc_ff - 16'h0001;
    end

    // Write enable latch
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            WRITE_ENABLE_LATCH <= 1'b0;
        else if (cs_rise && op_ff == flpw_pkg::OP_NONE
                 && cmd_ff == flpw_pkg::OPC_WRITE_ENABLE && cnt_ff == flpw_pkg::INSTR_BITS)
            WRITE_ENABLE_LATCH <= 1'b1;
        else if (op_done && op_ff != flpw_pkg::OP_UNLOCK)
            WRITE_ENABLE_LATCH <= 1'b0;
    end

    // Lock register: freeze bit and lock flag
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            LOCK_REG <= flpw_pkg::LOCK_REG_RST;
        else if (op_done)
        begin
            unique case (op_ff)
                flpw_pkg::OP_FREEZE:
                    LOCK_REG[flpw_pkg::FREEZE_POS] <= 1'b1;
                flpw_pkg::OP_CLRLOCK:
                    LOCK_REG[flpw_pkg::LOCK_POS] <= 1'b0;
                flpw_pkg::OP_UNLOCK:
                    if (new_secret_ff == secret_ff)
                        LOCK_REG[flpw_pkg::LOCK_POS] <= 1'b1;
                default:
                    LOCK_REG <= LOCK_REG;
            endcase
        end
    end

    // Capture received data at operation start
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            new_secret_ff <= '0;
        else if (nxt_op == flpw_pkg::OP_PROGRAM || nxt_op == flpw_pkg::OP_UNLOCK)
            new_secret_ff <= rx_secret;
    end

    // Stored secret and programmed flag
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            secret_ff  <= flpw_pkg::SECRET_RST;
            SECRET_SET <= 1'b0;
        end
        else if (op_done && op_ff == flpw_pkg::OP_PROGRAM)
        begin
            secret_ff  <= new_secret_ff;
            SECRET_SET <= 1'b1;
        end
    end

    // Dynamic protection bits, all at once
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            DYNAMIC_PROTECT_BIT <= {NUM_DYN{flpw_pkg::DYN_RST}};
        else if (op_done && op_ff == flpw_pkg::OP_GLOCK)
            DYNAMIC_PROTECT_BIT <= '0;
        else if (op_done && op_ff == flpw_pkg::OP_GUNLOCK)
            DYNAMIC_PROTECT_BIT <= '1;
    end
endmodule : flpw_lock

// [shared/flpw_pkg.sv]
package flpw_pkg;

    // Opcodes seen on the serial link
    localparam logic [7:0] OPC_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OPC_READ_STATUS    = 8'h05;
    localparam logic [7:0] OPC_READ_PROTECT   = 8'h2b;
    localparam logic [7:0] OPC_SET_FREEZE     = 8'h91;
    localparam logic [7:0] OPC_READ_SECRET    = 8'he7;
    localparam logic [7:0] OPC_PROGRAM_SECRET = 8'he8;
    localparam logic [7:0] OPC_UNLOCK_SECRET  = 8'he9;
    localparam logic [7:0] OPC_GANG_LOCK      = 8'h7e;
    localparam logic [7:0] OPC_GANG_UNLOCK    = 8'h98;
    localparam logic [7:0] OPC_CLEAR_LOCK     = 8'ha6;

    // Field positions
    localparam int FREEZE_POS = 7;          // Freeze bit in lock register
    localparam int LOCK_POS   = 0;          // Persistent lock flag
    localparam int PWMODE_POS = 2;          // Password mode bit of protection reg
    localparam int BUSY_POS   = 0;          // Status byte: busy
    localparam int LATCH_POS  = 1;          // Status byte: write enable latch

    // Frame lengths in bits
    localparam logic [6:0] INSTR_BITS  = 7'h08;
    localparam logic [6:0] SECRET_BITS = 7'h48;   // Opcode plus 64 data bits
    localparam logic [6:0] CNT_MAX     = 7'h7f;

    // Internal operation time
    localparam int CLK_PERIOD_NS = 8;
    localparam int OP_TIME_NS    = 2000;
    localparam int OP_CYC        = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] OP_CYC_W = 16'(OP_CYC);

    // Values after reset
    localparam logic [7:0]  LOCK_REG_RST = 8'h01;
    localparam logic [63:0] SECRET_RST   = 64'hffff_ffff_ffff_ffff;
    localparam logic        DYN_RST      = 1'b1;

    // Pins that cross into the system clock
    typedef struct packed {
        logic       sck;
        logic       csn;
        logic [3:0] io;
    } flpw_pin_t;

    // Pending internal operation
    typedef enum logic [2:0] {
        OP_NONE, OP_FREEZE, OP_PROGRAM, OP_UNLOCK, OP_GLOCK, OP_GUNLOCK, OP_CLRLOCK
    } flpw_op_t;

    // Active read stream
    typedef enum logic [1:0] {RD_NONE, RD_STATUS, RD_SECRET, RD_PROTECT} flpw_rd_t;

endpackage : flpw_pkg

// [core/flpw_sync.sv]
`timescale 1ns/1ns
// Three-stage synchroniser; output follows once stages two and three agree
module flpw_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_ff;   // Metastable stage
    logic [W-1:0] s2_ff;   // Second stage
    logic [W-1:0] s3_ff;   // Third stage

    // Shift chain
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Accept per bit when stages agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dout <= RST;
        else
            for (int i = 0; i < W; i++)
                if (s2_ff[i] == s3_ff[i])
                    dout[i] <= s3_ff[i];
    end
endmodule : flpw_sync

// [testbench/flpw_lock_sva.sv]
`timescale 1ns/1ns
// Port-level watch on the lock block
module flpw_lock_sva #(
    parameter int NUM_DYN   = 16,
    parameter int OP_CYCLES = 250
) (
    input wire logic               CLK_SYS,
    input wire logic               RSTN,
    input wire logic               CS_N,
    input wire logic               BUSY_FLAG,
    input wire logic               WRITE_ENABLE_LATCH,
    input wire logic [7:0]         LOCK_REG,
    input wire logic               SECRET_SET,
    input wire logic [NUM_DYN-1:0] DYNAMIC_PROTECT_BIT
);
    logic [15:0] busy_cnt_ff;    // Cycles spent busy so far

    // Count busy cycles, cleared while idle
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            busy_cnt_ff <= 16'h0000;
        else
            busy_cnt_ff <= BUSY_FLAG ? busy_cnt_ff + 16'h0001 : 16'h0000;
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    busy_len_a: assert property ($fell(BUSY_FLAG) |-> busy_cnt_ff >= 16'(OP_CYCLES - 1)
        && busy_cnt_ff <= 16'(OP_CYCLES)) else $error("busy length off");
    freeze_done_a: assert property ($rose(LOCK_REG[7]) |-> $fell(BUSY_FLAG)
        && !WRITE_ENABLE_LATCH) else $error("freeze not at end of busy");
    secret_done_a: assert property ($rose(SECRET_SET) |-> $fell(BUSY_FLAG)
        && !WRITE_ENABLE_LATCH) else $error("secret set not at end of busy");
    dyn_all_a: assert property (!$stable(DYNAMIC_PROTECT_BIT) |-> $fell(BUSY_FLAG)
        && (DYNAMIC_PROTECT_BIT == '0 || DYNAMIC_PROTECT_BIT == '1)) else $error("dyn bits");
    lock_flag_a: assert property ($changed(LOCK_REG[0]) |-> $fell(BUSY_FLAG))
        else $error("lock flag moved outside an operation");
    busy_cs_a: assert property ($rose(BUSY_FLAG) |-> CS_N && $past(CS_N, 4))
        else $error("busy before select rise");
    latch_steady_a: assert property (BUSY_FLAG && $past(BUSY_FLAG) |-> $stable(WRITE_ENABLE_LATCH))
        else $error("latch moved while busy");
    latch_rise_a: assert property ($rose(WRITE_ENABLE_LATCH) |-> !BUSY_FLAG && CS_N)
        else $error("latch set while busy or in frame");

    // Main scenarios reached
    cover property ($rose(LOCK_REG[7]));
    cover property ($rose(SECRET_SET));
    cover property ($fell(DYNAMIC_PROTECT_BIT[0]));
endmodule : flpw_lock_sva

bind flpw_lock flpw_lock_sva #(.NUM_DYN(NUM_DYN), .OP_CYCLES(OP_CYCLES)) flpw_lock_sva_i (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .CS_N(CS_N), .BUSY_FLAG(BUSY_FLAG),
    .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .LOCK_REG(LOCK_REG),
    .SECRET_SET(SECRET_SET), .DYNAMIC_PROTECT_BIT(DYNAMIC_PROTECT_BIT));

// [testbench/flpw_host.sv]
`timescale 1ns/1ns
// Host controller on the link; its clock idles low outside frames
module flpw_host (
    input  wire logic  clk,
    output logic       sck,
    output logic       cs_n,
    output logic [3:0] io,
    input  wire logic  so,
    input  wire logic  so_oe
);
    logic oe_seen;    // Output enable noticed in the last frame

    // Idle pins: select high, clock low
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        io = 4'h0;
        oe_seen = 1'b0;
    end

    // Wait system cycles while watching the output enable
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (so_oe === 1'b1) oe_seen = 1'b1;
        end
    endtask : tick

    // One frame: nb bits out, MSB first, then nrx bits read back
    task automatic xfer(input logic [71:0] tx, input int nb, input int nrx,
                        input logic quad, output logic [63:0] rx);
        int i;
        rx = 64'h0;
        oe_seen = 1'b0;
        cs_n <= 1'b0;
        tick(5);
        for (i = 0; i < nb; i += (quad ? 4 : 1))
        begin
            sck <= 1'b0;
            if (quad) io <= tx[nb-1-i -: 4];
            else io[0] <= tx[nb-1-i];
            tick(5);
            sck <= 1'b1;
            tick(5);
        end
        repeat (nrx)
        begin
            sck <= 1'b0;
            tick(5);
            sck <= 1'b1;
            tick(5);
            rx = {rx[62:0], so};
        end
        sck <= 1'b0;
        tick(5);
        cs_n <= 1'b1;
        io <= ~io;       // Released lines show no stale value
        tick(8);
    endtask : xfer
endmodule : flpw_host

// [testbench/flpw_lock_tb_top.sv]
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
// Bench for the lock block driven by a host model
module flpw_lock_tb_top;
    localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;    // Test secret
    logic        clk_sys, rstn, quad, sck, cs_n, so_out, so_oe, busy, we_latch, secret_set;
    logic [3:0]  io;
    logic [15:0] apr, dyn;
    logic [7:0]  lock_reg;
    logic [63:0] rx, e;
    int          fail_count, total_checks;

    flpw_lock #(.NUM_DYN(16), .OP_CYCLES(400)) flpw_lock_i (.CLK_SYS(clk_sys), .RSTN(rstn),
        .SCK(sck), .CS_N(cs_n), .IO_IN(io), .QUAD_COMMAND_MODE(quad),
        .ADVANCED_PROTECTION_REG(apr), .SO_OUT(so_out), .SO_OE(so_oe), .BUSY_FLAG(busy),
        .WRITE_ENABLE_LATCH(we_latch), .LOCK_REG(lock_reg), .SECRET_SET(secret_set),
        .DYNAMIC_PROTECT_BIT(dyn));
    flpw_host flpw_host_i (.clk(clk_sys), .sck(sck), .cs_n(cs_n), .io(io), .so(so_out),
        .so_oe(so_oe));

    always #4 clk_sys = ~clk_sys;

    // Byte 0 first on the wire, MSB of each byte first
    function automatic logic [63:0] wire_order(input logic [63:0] v);
        int b;
        logic [63:0] r;
        for (b = 0; b < 8; b++) r[63-8*b -: 8] = v[8*b +: 8];
        return r;
    endfunction : wire_order

    // Verdict and end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // Frame with a read tail
    task automatic xf(input logic [71:0] tx, input int nb, input int nrx);
        flpw_host_i.xfer(tx, nb, nrx, quad, rx);
    endtask : xf

    // Mode pins change on a rising edge
    task automatic set_mode(input logic q, input logic [15:0] a);
        @(posedge clk_sys);
        quad <= q;
        apr <= a;
        @(posedge clk_sys);
    endtask : set_mode

    // See whether an operation starts, then wait for its end
    task automatic run_op(input logic exp);
        int n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 30 && !seen; n++)
        begin
            @(negedge clk_sys);
            seen = (busy === 1'b1);
        end
        `CHK(seen, exp)
        for (n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clk_sys);
        if (busy !== 1'b0)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, busy, 1'b0);
            summarize();
        end
    endtask : run_op

    // Secret program, read back and refusals
    task automatic s_program();
        e = wire_order(PW);
        xf({64'h0, flpw_pkg::OPC_READ_PROTECT}, 8, 16);
        `CHK(rx[15:0], {apr[7:0], apr[15:8]})
        xf({64'h0, flpw_pkg::OPC_READ_SECRET}, 8, 8);
        `CHK(flpw_host_i.oe_seen, 1'b0)
        xf({64'h0, flpw_pkg::OPC_WRITE_ENABLE}, 8, 0);
        xf({flpw_pkg::OPC_PROGRAM_SECRET, e}, 72, 0);
        run_op(1'b1);
        `CHK({secret_set, we_latch}, 2'b10)
        xf({64'h0, flpw_pkg::OPC_READ_SECRET}, 8, 72);
        `CHK(rx, {e[55:0], e[63:56]})
        set_mode(1'b1, 16'hc31e);
        xf({64'h0, flpw_pkg::OPC_READ_SECRET}, 8, 8);
        `CHK(flpw_host_i.oe_seen, 1'b0)
        set_mode(1'b0, 16'hc31a);
        xf({64'h0, flpw_pkg::OPC_READ_SECRET}, 8, 8);
        `CHK(flpw_host_i.oe_seen, 1'b0)
        xf({64'h0, flpw_pkg::OPC_WRITE_ENABLE}, 8, 0);
        xf({flpw_pkg::OPC_PROGRAM_SECRET, ~e}, 72, 0);
        run_op(1'b0);
        set_mode(1'b0, 16'hc31e);
    endtask : s_program

    // Lock flag clear, wrong and right unlock
    task automatic s_unlock();
        xf({64'h0, flpw_pkg::OPC_CLEAR_LOCK}, 8, 0);
        run_op(1'b1);
        `CHK(lock_reg[0], 1'b0)
        xf({flpw_pkg::OPC_UNLOCK_SECRET, ~e}, 72, 0);
        run_op(1'b1);
        `CHK(lock_reg[0], 1'b0)
        xf({flpw_pkg::OPC_UNLOCK_SECRET, e}, 72, 0);
        run_op(1'b1);
        `CHK(lock_reg[0], 1'b1)
    endtask : s_unlock

    // Gang lock in quad mode, gang unlock in serial mode
    task automatic s_gang();
        set_mode(1'b1, 16'hc31e);
        xf({64'h0, flpw_pkg::OPC_WRITE_ENABLE}, 8, 0);
        xf({60'h0, flpw_pkg::OPC_GANG_LOCK, 4'h0}, 12, 0);
        run_op(1'b0);
        xf({64'h0, flpw_pkg::OPC_GANG_LOCK}, 8, 0);
        run_op(1'b1);
        `CHK(dyn, 16'h0000)
        set_mode(1'b0, 16'hc31e);
        xf({64'h0, flpw_pkg::OPC_WRITE_ENABLE}, 8, 0);
        xf({56'h0, flpw_pkg::OPC_GANG_UNLOCK, 8'h00}, 16, 0);
        run_op(1'b1);
        `CHK(dyn, 16'hffff)
    endtask : s_gang

    // Freeze without latch, misaligned, then with status poll while busy
    task automatic s_freeze();
        xf({64'h0, flpw_pkg::OPC_SET_FREEZE}, 8, 0);
        run_op(1'b0);
        xf({64'h0, flpw_pkg::OPC_WRITE_ENABLE}, 8, 0);
        xf({63'h0, flpw_pkg::OPC_SET_FREEZE, 1'b0}, 9, 0);
        run_op(1'b0);
        `CHK(we_latch, 1'b1)
        xf({64'h0, flpw_pkg::OPC_SET_FREEZE}, 8, 0);
        xf({64'h0, flpw_pkg::OPC_READ_STATUS}, 8, 8);
        `CHK(rx[7:0], 8'h03)
        xf({64'h0, flpw_pkg::OPC_CLEAR_LOCK}, 8, 0);
        run_op(1'b1);
        `CHK({lock_reg, we_latch}, {8'h81, 1'b0})
    endtask : s_freeze

    // Reset, then the scenarios in order
    initial
    begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        quad = 1'b0;
        apr = 16'hc31e;
        fail_count = 0;
        total_checks = 0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        s_program();
        s_unlock();
        s_gang();
        s_freeze();
        summarize();
    end
endmodule : flpw_lock_tb_top
